//--- inc/sbcwd_pkg.sv
// constants, command words, modes and carriers of the watchdog and mode control block
// assumes an spi slave upstream that hands over one decoded 16-bit word per frame end
//
// Behaviour
// - low-power supply-on mode: main regulator on, can and aux regulators and pass drive off
// - mode word 0x5C10 in low-power supply-on mode is a wake-up
// - overcurrent longer than selected time up to 32 ms flags a wake-up
// - every wake-up from low-power supply-on mode pulses the alert output low
// - optional low-power timeout watchdog, refreshed by dedicated command or brief overcurrent
// - in low-power mode any other command or bare chip select wakes up
// - secured request shows random code; next command must return its transform
// - normal to init, flash or reset only via the secured procedure
// - critical settings writable only in init entered from power-up or via the secured procedure
// - normal-request timeout is 256 ms, shorter configurable after low-power wake
// - window, timeout or advanced type chosen in init, then locked
// - window type: refresh before half period or none by end forces reset
// - window runs in normal only; period kept in low power, default after power loss
// - debug mode: watchdog counts but never resets or changes mode
// - debug left by spi restarts period; left by pin forces reset
// - flash mode: long timeout only, optional alert pulse at half period
// - advanced refresh returns inverted random byte in 1, 2 or 4 writes, msb first
// - init watchdog bits 1 to 3 set type and count; period set separately
// - leaving init or normal-request for normal needs plain refresh 0x5A00
// - simple refresh 0x5A00 anytime, or second half only when window bit set
// - command 0x1B00 returns random code in low byte of answer
// - single advanced refresh is 0x5A with inverted byte; a new code follows
// - wrong or missing refresh in normal mode forces reset
// - two-write refresh: upper inverted nibble then lower inverted nibble
package sbcwd_pkg;

  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int ALERT_PULSE_US = 100;
  localparam int ALERT_CYC = CLK_HZ / 1_000_000 * ALERT_PULSE_US;
  localparam logic [15:0] RESET_MS = 16'h0001;
  localparam logic [15:0] NR_TIMEOUT_MS = 16'h0100;
  localparam logic [15:0] INIT_TIMEOUT_MS = 16'h0100;
  localparam logic [15:0] NR_SHORT_MAX_MS = 16'h0080;
  localparam logic [15:0] NORM_PERIOD_MAX_MS = 16'h0100;
  localparam logic [15:0] FLASH_PERIOD_MAX_MS = 16'h8000;
  localparam logic [5:0] OC_STEP_MS = 6'h04;

  // command words and opcodes
  localparam logic [15:0] CMD_REFRESH = 16'h5A00;
  localparam logic [7:0] OP_REFRESH = 8'h5A;
  localparam logic [15:0] CMD_RND_READ = 16'h1B00;
  localparam logic [15:0] CMD_WAKE_NR = 16'h5C10;
  localparam logic [15:0] CMD_LP_ENTER = 16'h5C20;
  localparam logic [15:0] CMD_FLASH_EXIT = 16'h5C40;
  localparam logic [15:0] CMD_DBG_EXIT = 16'h5C80;
  localparam logic [15:0] CMD_LP_REFRESH = 16'h5B00;
  localparam logic [7:0] OP_SEC_REQ = 8'h56;
  localparam logic [7:0] OP_SEC_KEY = 8'h57;
  localparam logic [7:0] OP_INIT_WD = 8'h58;
  localparam logic [7:0] OP_NR_TIMEOUT = 8'h59;
  localparam logic [7:0] OP_PERIOD = 8'h5E;
  localparam logic [7:0] OP_LP_CFG = 8'h5F;

  // secured targets
  localparam logic [1:0] SEC_NONE = 2'h0;
  localparam logic [1:0] SEC_TO_INIT = 2'h1;
  localparam logic [1:0] SEC_TO_FLASH = 2'h2;
  localparam logic [1:0] SEC_TO_RESET = 2'h3;

  // field positions
  localparam int WD_WIN_BIT = 1;
  localparam int WD_ADV_LSB = 2;
  localparam int LP_WD_EN_BIT = 0;
  localparam int FLASH_INT_BIT = 1;
  localparam int OC_SEL_LSB = 2;

  // advanced piece counts
  localparam logic [1:0] ADV_OFF = 2'h0;
  localparam logic [1:0] ADV_ONE = 2'h1;
  localparam logic [1:0] ADV_TWO = 2'h2;
  localparam logic [1:0] ADV_FOUR = 2'h3;

  // reset values
  localparam logic WIN_SEL_RST = 1'b1;
  localparam logic [1:0] ADV_SEL_RST = 2'h0;
  localparam logic [1:0] PERIOD_SEL_RST = 2'h0;
  localparam logic [1:0] NR_SHORT_SEL_RST = 2'h0;
  localparam logic [2:0] OC_SEL_RST = 3'h7;

  typedef enum logic [2:0] {
    MODE_INIT_RESET,
    MODE_INIT,
    MODE_RESET,
    MODE_NORMAL_REQ,
    MODE_NORMAL,
    MODE_LP_VDD_ON,
    MODE_FLASH
  } sbcwd_mode_e;

  typedef struct packed {
    logic [7:0] op;
    logic [7:0] arg;
  } sbcwd_cmd_s;

  typedef struct packed {
    logic mainOn;
    logic canOn;
    logic auxOn;
    logic passOn;
  } sbcwd_supply_s;

endpackage

//--- logic/sbcwd_msdiv.sv
// millisecond enable divider, restartable
// assumes clr comes from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module sbcwd_msdiv #(
  parameter int DIV_CYC = 40000
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // control
  input wire logic clr,
  // enable pulse
  output logic tick
);
  localparam logic [15:0] LAST = 16'(DIV_CYC - 1);
  logic [15:0] cnt_r;

  // restart keeps every period an exact number of milliseconds
  always_ff @(posedge mclk) begin
    if (sys_rst || clr) begin
      cnt_r <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt_r == LAST) begin
      cnt_r <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule // sbcwd_msdiv
`default_nettype wire

//--- logic/sbcwd_rndgen.sv
// free running pseudo random byte source
// assumes one clock; value is read only when a new code is issued
`timescale 1ns/1ps
`default_nettype none
module sbcwd_rndgen (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // random byte
  output logic [7:0] rndByte
);
  logic [15:0] lfsr_r;

  // galois lfsr, maximal length; host timing makes the sampled value unpredictable
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lfsr_r <= 16'hACE1;
    end else begin
      lfsr_r <= {1'b0, lfsr_r[15:1]} ^ (lfsr_r[0] ? 16'hB400 : 16'h0000);
    end
  end

  assign rndByte = lfsr_r[7:0];
endmodule // sbcwd_rndgen
`default_nettype wire

//--- logic/sbcwd_top.sv
// mode control and software watchdog of the system basis chip
// assumes decoded spi words arrive as one-cycle strobes on mclk; pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
module sbcwd_top #(
  parameter int TICK_CYC = sbcwd_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // spi word strobe from the frame decoder
  input wire logic cmdValid,
  input wire sbcwd_pkg::sbcwd_cmd_s cmdWord,
  input wire logic csBare,
  output logic [15:0] rspWord,
  // pins
  input wire logic debug_select_pin,
  input wire logic ocPin,
  input wire logic extWakePin,
  output logic alertN,
  output logic rstN,
  // status
  output sbcwd_pkg::sbcwd_mode_e mode,
  output sbcwd_pkg::sbcwd_supply_s supply,
  output logic debugActive,
  output logic powerLoss,
  output logic [1:0] watchdog_period_select_reg,
  output logic [7:0] random_code
);
  import sbcwd_pkg::*;

  function automatic logic [7:0] pieceMask(input logic [1:0] adv, input logic [1:0] step);
    unique case (adv)
      ADV_ONE: pieceMask = 8'hFF;
      ADV_TWO: pieceMask = step[0] ? 8'h0F : 8'hF0;
      ADV_FOUR: pieceMask = 8'hC0 >> {step, 1'b0};
      default: pieceMask = 8'h00;
    endcase
  endfunction

  function automatic logic [1:0] lastStep(input logic [1:0] adv);
    lastStep = (adv == ADV_FOUR) ? 2'h3 : ((adv == ADV_TWO) ? 2'h1 : 2'h0);
  endfunction

  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic dbgPin;
  logic ocS;
  logic wakeS;
  logic [1:0] startCnt_r;
  logic ocPrev_r;
  logic [5:0] ocCnt_r;
  logic [5:0] ocLimit;
  logic ocTick;
  logic wdTick;
  logic [7:0] lfsrByte;
  logic [7:0] rnd_r;
  logic [1:0] secPend_r;
  logic [1:0] advStep_r;
  logic [15:0] msCnt_r;
  logic [15:0] curPeriod;
  logic [11:0] alertCnt_r;
  logic winSel_r;
  logic [1:0] advSel_r;
  logic [1:0] periodSel_r;
  logic [1:0] nrShortSel_r;
  logic nrShort_r;
  logic lpWdEn_r;
  logic flashIntEn_r;
  logic [2:0] ocSel_r;
  logic cfgOpen_r;
  logic dbg_r;
  sbcwd_mode_e mode_r;
  sbcwd_mode_e mode_nxt;
  logic expired;
  logic early;
  logic halfHit;
  logic ocWake;
  logic ocBrief;
  logic wakeEv;
  logic goodFinal;
  logic goodPart;
  logic secDone;
  logic secReq;
  logic dbgSpiExit;
  logic dbgPinExit;
  logic wdRestart;
  logic [7:0] expByte;

  // two flops on every pin before use
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else begin
      sync1_r <= {extWakePin, ocPin, debug_select_pin};
      sync2_r <= sync1_r;
    end
  end
  assign dbgPin = sync2_r[0];
  assign ocS = sync2_r[1];
  assign wakeS = sync2_r[2];

  sbcwd_msdiv #(.DIV_CYC(TICK_CYC)) u_wdTick (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clr(wdRestart),
    .tick(wdTick)
  );

  sbcwd_msdiv #(.DIV_CYC(TICK_CYC)) u_ocTick (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clr(!ocS),
    .tick(ocTick)
  );

  sbcwd_rndgen u_rnd (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .rndByte(lfsrByte)
  );

  // period of the running watchdog phase
  always_comb begin
    unique case (mode_r)
      MODE_INIT_RESET, MODE_RESET: curPeriod = RESET_MS;
      MODE_INIT: curPeriod = INIT_TIMEOUT_MS;
      MODE_NORMAL_REQ: curPeriod = nrShort_r ? (NR_SHORT_MAX_MS >> nrShortSel_r) : NR_TIMEOUT_MS;
      MODE_FLASH: curPeriod = FLASH_PERIOD_MAX_MS >> periodSel_r;
      MODE_NORMAL, MODE_LP_VDD_ON: curPeriod = NORM_PERIOD_MAX_MS >> periodSel_r;
      // spare enum code: shortest period, but no sequencing branch leaves that code
      default: curPeriod = RESET_MS;
    endcase
  end

  assign expired = wdTick && (msCnt_r == curPeriod - 16'h0001);
  assign early = msCnt_r < (curPeriod >> 1);
  assign halfHit = wdTick && (mode_r == MODE_FLASH) && flashIntEn_r
    && (msCnt_r == (curPeriod >> 1) - 16'h0001);
  assign ocLimit = ({3'h0, ocSel_r} * OC_STEP_MS) + OC_STEP_MS;
  assign ocWake = (mode_r == MODE_LP_VDD_ON) && ocS && ocTick
    && (ocCnt_r == ocLimit - 6'h01);
  assign ocBrief = (mode_r == MODE_LP_VDD_ON) && lpWdEn_r && !ocS && ocPrev_r;
  assign expByte = ~rnd_r & pieceMask(advSel_r, advStep_r);
  assign dbgPinExit = dbg_r && !dbgPin && (startCnt_r == 2'h3);
  assign dbgSpiExit = dbg_r && cmdValid && (cmdWord == CMD_DBG_EXIT);

  // mode sequencing
  always_comb begin
    mode_nxt = mode_r;
    wakeEv = 1'b0;
    goodFinal = 1'b0;
    goodPart = 1'b0;
    secDone = 1'b0;
    secReq = 1'b0;
    unique case (mode_r)
      MODE_INIT_RESET: begin
        if (expired) mode_nxt = MODE_INIT;
      end
      MODE_RESET: begin
        if (expired) mode_nxt = MODE_NORMAL_REQ;
      end
      MODE_INIT: begin
        if (cmdValid && cmdWord == CMD_REFRESH) mode_nxt = MODE_NORMAL;
        else if (expired && !dbg_r) mode_nxt = MODE_INIT_RESET;
      end
      MODE_NORMAL_REQ: begin
        if (cmdValid && cmdWord == CMD_REFRESH) mode_nxt = MODE_NORMAL;
        else if (expired && !dbg_r) mode_nxt = MODE_RESET;
      end
      MODE_NORMAL: begin
        if (cmdValid && cmdWord.op == OP_REFRESH) begin
          if (advSel_r == ADV_OFF) begin
            if (cmdWord.arg == 8'h00 && !(winSel_r && early)) goodFinal = 1'b1;
            else if (!dbg_r) mode_nxt = MODE_RESET;
          end else if (cmdWord.arg != expByte) begin
            if (!dbg_r) mode_nxt = MODE_RESET;
          end else if (advStep_r != lastStep(advSel_r)) begin
            goodPart = 1'b1;
          end else if (winSel_r && early) begin
            if (!dbg_r) mode_nxt = MODE_RESET;
          end else begin
            goodFinal = 1'b1;
          end
        end else if (cmdValid && cmdWord.op == OP_SEC_KEY && secPend_r != SEC_NONE) begin
          if (cmdWord.arg == ~rnd_r) begin
            secDone = 1'b1;
            unique case (secPend_r)
              SEC_TO_INIT: mode_nxt = MODE_INIT;
              SEC_TO_FLASH: mode_nxt = MODE_FLASH;
              default: mode_nxt = MODE_RESET;
            endcase
          end
        end else if (cmdValid && cmdWord.op == OP_SEC_REQ && cmdWord.arg[1:0] != SEC_NONE) begin
          secReq = 1'b1;
        end else if (cmdValid && cmdWord == CMD_LP_ENTER) begin
          mode_nxt = MODE_LP_VDD_ON;
        end else if (expired && !dbg_r) begin
          mode_nxt = MODE_RESET;
        end
      end
      MODE_LP_VDD_ON: begin
        if ((cmdValid && !(lpWdEn_r && cmdWord == CMD_LP_REFRESH)) || csBare) begin
          wakeEv = 1'b1;
        end else if (wakeS || ocWake) begin
          wakeEv = 1'b1;
        end
        if (wakeEv) mode_nxt = MODE_NORMAL_REQ;
        else if (lpWdEn_r && expired && !dbg_r) mode_nxt = MODE_RESET;
      end
      MODE_FLASH: begin
        if (cmdValid && cmdWord == CMD_FLASH_EXIT) mode_nxt = MODE_RESET;
        else if (cmdValid && cmdWord.op == OP_REFRESH && cmdWord.arg != 8'h00 && !dbg_r)
          mode_nxt = MODE_RESET;
        else if (expired && !dbg_r) mode_nxt = MODE_RESET;
      end
    endcase
    if (dbgPinExit) mode_nxt = MODE_RESET;
  end

  // a period restarts on any mode change, good refresh or spi debug exit
  assign wdRestart = (mode_nxt != mode_r) || goodFinal || dbgSpiExit
    || (mode_r == MODE_FLASH && cmdValid && cmdWord == CMD_REFRESH)
    || ((mode_r == MODE_LP_VDD_ON) && !wakeEv
        && ((cmdValid && cmdWord == CMD_LP_REFRESH) || ocBrief))
    || (expired && mode_nxt == mode_r);

  always_ff @(posedge mclk) begin
    if (sys_rst) mode_r <= MODE_INIT_RESET;
    else mode_r <= mode_nxt;
  end

  // watchdog millisecond count, keeps running in debug
  always_ff @(posedge mclk) begin
    if (sys_rst || wdRestart) msCnt_r <= 16'h0000;
    else if (wdTick) msCnt_r <= msCnt_r + 16'h0001;
  end

  // overcurrent duration in low power
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ocPrev_r <= 1'b0;
      ocCnt_r <= 6'h00;
    end else begin
      ocPrev_r <= ocS;
      if (!ocS) ocCnt_r <= 6'h00;
      else if (ocTick && ocCnt_r != ocLimit) ocCnt_r <= ocCnt_r + 6'h01;
    end
  end

  // advanced refresh progress and random code
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      advStep_r <= 2'h0;
      secPend_r <= SEC_NONE;
      rnd_r <= 8'h00;
    end else begin
      if (goodPart) advStep_r <= advStep_r + 2'h1;
      else if (goodFinal || mode_nxt != MODE_NORMAL) advStep_r <= 2'h0;
      // a pending request lives for exactly the next command
      if (secReq) secPend_r <= cmdWord.arg[1:0];
      else if (cmdValid) secPend_r <= SEC_NONE;
      if (goodFinal || secDone || secReq || startCnt_r == 2'h2) rnd_r <= lfsrByte;
    end
  end

  // answer word for the next frame
  always_ff @(posedge mclk) begin
    if (sys_rst) rspWord <= 16'h0000;
    else if (goodFinal || secReq) rspWord <= {8'h00, lfsrByte};
    else if (cmdValid && cmdWord == CMD_RND_READ) rspWord <= {8'h00, rnd_r};
  end

  // configuration; critical fields only while the init window is open
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      winSel_r <= WIN_SEL_RST;
      advSel_r <= ADV_SEL_RST;
      periodSel_r <= PERIOD_SEL_RST;
      nrShortSel_r <= NR_SHORT_SEL_RST;
      lpWdEn_r <= 1'b0;
      flashIntEn_r <= 1'b0;
      ocSel_r <= OC_SEL_RST;
      cfgOpen_r <= 1'b1;
      powerLoss <= 1'b1;
    end else begin
      if (cmdValid && mode_r == MODE_INIT && cfgOpen_r) begin
        if (cmdWord.op == OP_INIT_WD) begin
          winSel_r <= cmdWord.arg[WD_WIN_BIT];
          advSel_r <= cmdWord.arg[WD_ADV_LSB+:2];
        end
        if (cmdWord.op == OP_NR_TIMEOUT) nrShortSel_r <= cmdWord.arg[1:0];
        if (cmdWord.op == OP_LP_CFG) begin
          lpWdEn_r <= cmdWord.arg[LP_WD_EN_BIT];
          flashIntEn_r <= cmdWord.arg[FLASH_INT_BIT];
          ocSel_r <= cmdWord.arg[OC_SEL_LSB+:3];
        end
      end
      if (cmdValid && cmdWord.op == OP_PERIOD
          && (mode_r == MODE_INIT || mode_r == MODE_NORMAL || mode_r == MODE_NORMAL_REQ))
        periodSel_r <= cmdWord.arg[1:0];
      if (secDone && secPend_r == SEC_TO_INIT) cfgOpen_r <= 1'b1;
      else if (mode_r == MODE_INIT && mode_nxt != MODE_INIT) cfgOpen_r <= 1'b0;
      if (mode_r == MODE_INIT && mode_nxt == MODE_NORMAL) powerLoss <= 1'b0;
    end
  end

  // short normal-request timeout only after a low-power wake
  always_ff @(posedge mclk) begin
    if (sys_rst) nrShort_r <= 1'b0;
    else if (wakeEv) nrShort_r <= 1'b1;
    else if (mode_nxt == MODE_RESET) nrShort_r <= 1'b0;
  end

  // debug caught once after reset release, once the pin synchroniser is full
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      startCnt_r <= 2'h0;
      dbg_r <= 1'b0;
    end else begin
      if (startCnt_r != 2'h3) startCnt_r <= startCnt_r + 2'h1;
      if (startCnt_r == 2'h2) dbg_r <= dbgPin;
      else if (dbgSpiExit || dbgPinExit) dbg_r <= 1'b0;
    end
  end

  // alert pulse; a new event restarts it rather than being lost
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      alertCnt_r <= 12'h000;
      alertN <= 1'b1;
    end else if (wakeEv || halfHit) begin
      alertCnt_r <= 12'(ALERT_CYC - 1);
      alertN <= 1'b0;
    end else if (alertCnt_r != 12'h000) begin
      alertCnt_r <= alertCnt_r - 12'h001;
    end else begin
      alertN <= 1'b1;
    end
  end

  // pin and supply outputs follow the next mode so they change with it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rstN <= 1'b0;
      supply <= '{mainOn: 1'b1, canOn: 1'b0, auxOn: 1'b0, passOn: 1'b0};
    end else begin
      rstN <= !(mode_nxt == MODE_RESET || mode_nxt == MODE_INIT_RESET);
      supply.mainOn <= 1'b1;
      supply.canOn <= mode_nxt == MODE_NORMAL || mode_nxt == MODE_FLASH
        || (dbg_r && mode_nxt != MODE_LP_VDD_ON);
      supply.auxOn <= mode_nxt == MODE_NORMAL;
      supply.passOn <= mode_nxt == MODE_NORMAL || mode_nxt == MODE_FLASH;
    end
  end

  assign mode = mode_r;
  assign debugActive = dbg_r;
  assign watchdog_period_select_reg = periodSel_r;
  assign random_code = rnd_r;
endmodule // sbcwd_top
`default_nettype wire

//--- test/sbcwd_chk.sv
// port assertions of the watchdog and mode control block
// assumes it is bound to sbcwd_top; one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module sbcwd_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // command side
  input wire logic cmdValid,
  input wire sbcwd_pkg::sbcwd_cmd_s cmdWord,
  input wire logic csBare,
  input wire logic [15:0] rspWord,
  // pins
  input wire logic debug_select_pin,
  input wire logic alertN,
  input wire logic rstN,
  // status
  input wire sbcwd_pkg::sbcwd_mode_e mode,
  input wire sbcwd_pkg::sbcwd_supply_s supply,
  input wire logic debugActive,
  input wire logic [7:0] random_code
);
  import sbcwd_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_rst_pin_mode: assert property (rstN == !(mode inside {MODE_RESET, MODE_INIT_RESET}))
    else $error("reset pin disagrees with mode");
  a_lp_supply: assert property (mode == MODE_LP_VDD_ON |-> supply == 4'b1000)
    else $error("wrong regulators in low power");
  a_wake_word: assert property (cmdValid && cmdWord == CMD_WAKE_NR &&
    mode == MODE_LP_VDD_ON |=> mode == MODE_NORMAL_REQ)
    else $error("wake word ignored");
  a_bare_wake: assert property (csBare && mode == MODE_LP_VDD_ON |=>
    mode == MODE_NORMAL_REQ)
    else $error("bare select did not wake");
  a_wake_alert: assert property ($past(mode) == MODE_LP_VDD_ON &&
    mode == MODE_NORMAL_REQ |-> ##[0:1] !alertN)
    else $error("wake without alert pulse");
  a_alert_width: assert property ($fell(alertN) |=> !alertN [*8])
    else $error("alert pulse too short");
  a_leave_init: assert property (cmdValid && cmdWord == CMD_REFRESH &&
    mode inside {MODE_INIT, MODE_NORMAL_REQ} |=> mode == MODE_NORMAL)
    else $error("plain refresh did not reach normal");
  a_secured_only: assert property ($past(mode) == MODE_NORMAL &&
    mode inside {MODE_INIT, MODE_FLASH} |-> $past(cmdValid) && $past(cmdWord.op) == OP_SEC_KEY)
    else $error("protected mode change without key");
  // pin must be high long enough that the synced copy is high too
  a_debug_calm: assert property (debugActive && $past(debugActive) && debug_select_pin &&
    $past(debug_select_pin, 3) && !$past(cmdValid) &&
    $past(mode) inside {MODE_INIT, MODE_NORMAL, MODE_NORMAL_REQ} |-> mode == $past(mode))
    else $error("mode changed in debug");
  a_rnd_answer: assert property ($past(cmdValid) && $past(cmdWord) == CMD_RND_READ |->
    rspWord[7:0] == random_code)
    else $error("code read answer wrong");

  c_lp_wake: cover property (mode == MODE_LP_VDD_ON ##1 mode == MODE_NORMAL_REQ);
  c_debug_normal: cover property (debugActive && mode == MODE_NORMAL);
  c_secured_init: cover property ($past(mode) == MODE_NORMAL && mode == MODE_INIT);
endmodule // sbcwd_chk
`default_nettype wire

//--- test/sbcwd_host.sv
// host model: hands decoded spi words and bare selects to the block
// assumes the block takes strobes on the rising edge of mclk
`timescale 1ns/1ps
`default_nettype none
module sbcwd_host (
  // clock
  input wire logic mclk,
  // answer from the device
  input wire logic [15:0] rspWord,
  // strobes towards the device
  output var logic cmdValid,
  output var sbcwd_pkg::sbcwd_cmd_s cmdWord,
  output var logic csBare
);
  import sbcwd_pkg::*;
  initial begin
    cmdValid = 1'b0;
    cmdWord = '0;
    csBare = 1'b0;
  end
  // word held through the taking edge; leftovers inverted so nothing stale decodes
  task send(input logic [15:0] w);
    @(posedge mclk);
    cmdValid <= 1'b1;
    cmdWord <= w;
    @(posedge mclk);
    cmdValid <= 1'b0;
    cmdWord <= ~w;
  endtask
  task bare;
    @(posedge mclk);
    csBare <= 1'b1;
    @(posedge mclk);
    csBare <= 1'b0;
  endtask
  task secKey;
    send({OP_SEC_KEY, ~rspWord[7:0]});
  endtask
  task advRefresh;
    send({OP_REFRESH, ~rspWord[7:0]});
  endtask
endmodule // sbcwd_host
`default_nettype wire

//--- test/sbcwd_tb_top.sv
// self-checking bench of the watchdog and mode control block
// assumes a 40 MHz clock and a shortened millisecond divider
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module sbcwd_tb_top;
  import sbcwd_pkg::*;
  localparam int T = 20;
  typedef struct {logic [15:0] cmd; int dly; logic key; sbcwd_mode_e exp;} sbcwd_row_s;
  logic mclk, sys_rst, cmdValid, csBare, dbgPin, ocPin, extWakePin;
  logic alertN, rstN, debugActive, powerLoss;
  sbcwd_cmd_s cmdWord;
  logic [15:0] rspWord;
  sbcwd_mode_e mode;
  sbcwd_supply_s supply;
  logic [1:0] perSel;
  logic [7:0] rndCode;
  int err_total, checks, cyc;
  sbcwd_row_s rows [12] = '{
    '{16'h5A00, 0, 1'b0, MODE_NORMAL}, '{16'h5A00, 140 * T, 1'b0, MODE_NORMAL},
    '{16'h5601, 0, 1'b0, MODE_NORMAL}, '{16'h0000, 0, 1'b1, MODE_INIT},
    '{16'h5A00, 0, 1'b0, MODE_NORMAL}, '{16'h5A00, 0, 1'b0, MODE_RESET},
    '{16'h5A00, 40, 1'b0, MODE_NORMAL}, '{16'h5C20, 0, 1'b0, MODE_LP_VDD_ON},
    '{16'h5C10, 0, 1'b0, MODE_NORMAL_REQ}, '{16'h5A00, 0, 1'b0, MODE_NORMAL},
    '{16'h5C20, 0, 1'b0, MODE_LP_VDD_ON}, '{16'h1B00, 0, 1'b0, MODE_NORMAL_REQ}};

  sbcwd_host host (.mclk(mclk), .rspWord(rspWord), .cmdValid(cmdValid), .cmdWord(cmdWord),
    .csBare(csBare));
  sbcwd_top #(.TICK_CYC(T)) dut (.mclk(mclk), .sys_rst(sys_rst), .cmdValid(cmdValid),
    .cmdWord(cmdWord), .csBare(csBare), .rspWord(rspWord), .debug_select_pin(dbgPin),
    .ocPin(ocPin), .extWakePin(extWakePin), .alertN(alertN), .rstN(rstN), .mode(mode),
    .supply(supply), .debugActive(debugActive), .powerLoss(powerLoss),
    .watchdog_period_select_reg(perSel), .random_code(rndCode));

  always #12.5 mclk = ~mclk;
  // the whole run needs about 17000 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      end_of_test();
    end
  end

  task end_of_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task done(input string s);
    $display("test %s finished", s);
  endtask
  task wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task go(input logic [15:0] w, input sbcwd_mode_e e);
    host.send(w);
    wt(1);
    `CHK(mode, e)
  endtask
  task rst(input logic dbg);
    @(posedge mclk);
    sys_rst <= 1'b1;
    dbgPin <= dbg;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    wt(2 * T);
  endtask

  initial begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    dbgPin = 1'b0;
    ocPin = 1'b0;
    extWakePin = 1'b0;
    wt(2);
    `CHK(powerLoss, 1'b1)
    `CHK(supply, 4'b1000)
    @(posedge mclk) sys_rst <= 1'b0;
    wt(2 * T);
    `CHK(mode, MODE_INIT)
    foreach (rows[i]) begin
      repeat (rows[i].dly) @(posedge mclk);
      if (rows[i].key) host.secKey();
      else host.send(rows[i].cmd);
      wt(1);
      `CHK(mode, rows[i].exp)
    end
    `CHK(powerLoss, 1'b0)
    done("table");
    wt(126 * T);
    `CHK(mode, MODE_NORMAL_REQ)
    wt(2 * T + 3);
    `CHK(mode, MODE_RESET)
    `CHK(rstN, 1'b0)
    done("request timeout");
    wt(2 * T);
    go(16'h5A00, MODE_NORMAL);
    go(16'h5C20, MODE_LP_VDD_ON);
    host.bare();
    wt(1);
    `CHK(mode, MODE_NORMAL_REQ)
    `CHK(alertN, 1'b0)
    done("bare select");
    go(16'h5A00, MODE_NORMAL);
    go(16'h5C20, MODE_LP_VDD_ON);
    @(posedge mclk) ocPin <= 1'b1;
    wt(30 * T);
    `CHK(mode, MODE_LP_VDD_ON)
    wt(3 * T);
    `CHK(mode, MODE_NORMAL_REQ)
    @(posedge mclk) ocPin <= 1'b0;
    done("overcurrent");
    go(16'h5A00, MODE_NORMAL);
    wt(256 * T + 8);
    `CHK(mode, MODE_RESET)
    done("missing refresh");
    rst(1'b0);
    go(16'h5804, MODE_INIT);
    go(16'h5A00, MODE_NORMAL);
    go(16'h5E01, MODE_NORMAL);
    `CHK(perSel, 2'h1)
    host.send(CMD_RND_READ);
    wt(1);
    `CHK(rspWord[7:0], rndCode)
    host.advRefresh();
    wt(1);
    `CHK(mode, MODE_NORMAL)
    go({OP_REFRESH, ~rspWord[7:0] ^ 8'h01}, MODE_RESET);
    done("advanced");
    rst(1'b1);
    `CHK(debugActive, 1'b1)
    wt(256 * T + 30);
    `CHK(mode, MODE_INIT)
    go(16'h5A00, MODE_NORMAL);
    go(CMD_DBG_EXIT, MODE_NORMAL);
    `CHK(debugActive, 1'b0)
    rst(1'b1);
    @(posedge mclk) dbgPin <= 1'b0;
    wt(5);
    `CHK(mode, MODE_RESET)
    done("debug");
    end_of_test();
  end
endmodule // sbcwd_tb_top
bind sbcwd_top sbcwd_chk chk (.mclk(mclk), .sys_rst(sys_rst), .cmdValid(cmdValid),
  .cmdWord(cmdWord), .csBare(csBare), .rspWord(rspWord), .debug_select_pin(debug_select_pin),
  .alertN(alertN), .rstN(rstN), .mode(mode), .supply(supply), .debugActive(debugActive),
  .random_code(random_code));
`default_nettype wire
